// *** hdl/istd_defines.vh ***
/*
 Register offsets, field encodings, current-limit codes and timing counts
 for the input source type detector. Definitions only.
*/
`ifndef ISTD_DEFINES_VH
`define ISTD_DEFINES_VH
// ==========================================
// Register offsets (byte addresses)
`define ISTD_ADDR_CTRL 8'h00
`define ISTD_ADDR_STATUS 8'h04
`define ISTD_ADDR_FLAGS 8'h08
`define ISTD_ADDR_MASK 8'h0C
`define ISTD_ADDR_ILIM 8'h10
`define ISTD_ADDR_DRIVE 8'h14
`define ISTD_ADDR_ADC 8'h18
// ==========================================
// Control bit positions
`define ISTD_CTRL_AUTO 0
`define ISTD_CTRL_HV_EN 1
`define ISTD_CTRL_9V 2
`define ISTD_CTRL_12V 3
`define ISTD_CTRL_EXTCLAMP 4
`define ISTD_CTRL_OPT 5
`define ISTD_CTRL_RESET 8'h01
// ==========================================
// Source type codes
`define ISTD_SRC_NONE 4'h0
`define ISTD_SRC_SDP 4'h1
`define ISTD_SRC_CDP 4'h2
`define ISTD_SRC_DCP 4'h3
`define ISTD_SRC_HIGH_VOLTAGE_DCP 4'h4
`define ISTD_SRC_UNKNOWN 4'h5
`define ISTD_SRC_DIVIDER 4'h6
// ==========================================
// Current limits in mA
`define ISTD_ILIM_SDP 12'h1F4
`define ISTD_ILIM_CDP 12'h5DC
`define ISTD_ILIM_DCP 12'hCB2
`define ISTD_ILIM_HIGH_VOLTAGE_DCP 12'h5DC
`define ISTD_ILIM_UNKNOWN 12'hBB8
`define ISTD_ILIM_DIV1 12'h834
`define ISTD_ILIM_DIV2 12'h7D0
`define ISTD_ILIM_DIV3 12'h3E8
`define ISTD_ILIM_DIV4 12'h960
`define ISTD_ILIM_RESET 12'hBB8
// ==========================================
// Classification results from the analog front end
`define ISTD_CLS_SDP 3'h0
`define ISTD_CLS_CDP 3'h1
`define ISTD_CLS_DCP 3'h2
`define ISTD_CLS_OTHER 3'h3
// Start delay after detection, in microseconds
`define ISTD_START_DELAY_US 30000
`define ISTD_CLK_MHZ 40
`endif

// *** hdl/istd_detector.v ***
/*
 Input source type detector: sequences D+/D- detection, loads the
 input current limit and source-type code, and holds host drive levels.
 Assumes an analog front end that reports each stage's result with a
 done pulse, and a plain register port on the same clock.
*/
// Design decisions made here: the plain strobed port and the register addresses.
// What this block does
// [R01] Detect source type after qualification when enabled
// [R02] Port class done: status, flag, interrupt pulse
// [R03] Start high-voltage handshake on DCP if enabled
// [R04] Completion loads limit and source code
// [R05] Host overwrites limit; apply lower with clamp
// [R06] Detection disabled: skip, keep limit unchanged
// [R07] Stages: contact, primary, secondary, high-voltage
// [R08] Primary: standard class first, then dividers
// [R09] Secondary stage separates CDP from DCP
// [R10] Standard results load fixed limits and codes
// [R11] Divider adapters code 0110, per-divider limits
// [R12] Handshake needs enable plus request; 12V first
// [R13] Done clears detect status, flags, pulses interrupt
// [R14] DCP gets 3.25A, then 1.5A after handshake
// [R15] Host writes 1.5A, enables then disables handshake
// [R16] Host sets D+/D- drive levels; device drives
// [R17] Drive writes ignored while detection runs
// [R18] Detection applies to first auxiliary input only
// [R19] Host enumerates CDP within 2.5 seconds
// [R20] D+/D- converted readings visible to host
// [R21] Start only after poor source qualification
// [R22] Converter starts 30 ms after completion
// [R23] Source removal aborts, restarts at contact detect
// [R24] Unmatched pattern reports unknown adapter
`timescale 1ns/10ps
`include "istd_defines.vh"
module istd_detector #(
	parameter START_DELAY_CYCLES = `ISTD_START_DELAY_US * `ISTD_CLK_MHZ
) (
	input wire clk,
	input wire reset_n,
	input wire [7:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_write,
	input wire bus_read,
	output reg [31:0] bus_rdata,
	input wire first_aux_input,
	input wire source_qualified,
	input wire stage_done,
	input wire [2:0] class_result,
	input wire [2:0] divider_match,
	input wire hv_ack,
	input wire [11:0] clamp_ma,
	input wire [9:0] plus_line_adc,
	input wire [9:0] minus_line_adc,
	output reg [2:0] stage_req,
	output reg hv_request_12v,
	output reg [3:0] plus_line_drive_level,
	output reg [2:0] minus_line_drive_level,
	output wire [11:0] applied_current_limit,
	output reg converter_enable,
	output reg int_pulse
);
	// ==========================================
	// States
	localparam [6:0] ST_IDLE = 7'b000_0001;
	localparam [6:0] ST_CONTACT = 7'b000_0010;
	localparam [6:0] ST_PRIMARY = 7'b000_0100;
	localparam [6:0] ST_DIVIDER = 7'b000_1000;
	localparam [6:0] ST_SECOND = 7'b001_0000;
	localparam [6:0] ST_HV = 7'b010_0000;
	localparam [6:0] ST_DONE = 7'b100_0000;
	localparam [2:0] REQ_NONE = 3'h0;
	localparam [2:0] REQ_CONTACT = 3'h1;
	localparam [2:0] REQ_PRIMARY = 3'h2;
	localparam [2:0] REQ_DIVIDER = 3'h3;
	localparam [2:0] REQ_SECOND = 3'h4;
	localparam [2:0] REQ_HV = 3'h5;
	localparam [31:0] DELAY_LAST = START_DELAY_CYCLES - 1;

	// Divider number to current limit, used for each divider match
	function [11:0] div_limit;
		input [2:0] d;
		begin
			case (d)
				3'h1: div_limit = `ISTD_ILIM_DIV1;
				3'h2: div_limit = `ISTD_ILIM_DIV2;
				3'h3: div_limit = `ISTD_ILIM_DIV3;
				3'h4: div_limit = `ISTD_ILIM_DIV4;
				default: div_limit = `ISTD_ILIM_UNKNOWN;
			endcase
		end
	endfunction

	reg [6:0] state_reg;
	reg [7:0] ctrl_reg;
	reg [11:0] ilim_reg;
	reg [3:0] src_code_reg;
	reg port_done_status_reg;
	reg line_detect_status_reg;
	reg port_class_done_flag;
	reg line_detect_done_flag;
	reg port_class_done_mask;
	reg line_detect_done_mask;
	reg hv_twelve_tried_reg;
	reg [31:0] delay_reg;
	reg delay_run_reg;
	reg [2:0] aux_sync;
	reg aux_level;
	reg [2:0] qual_sync;
	reg qual_level;

	wire auto_en = ctrl_reg[`ISTD_CTRL_AUTO];
	wire hv_en = ctrl_reg[`ISTD_CTRL_HV_EN];
	wire req_9v = ctrl_reg[`ISTD_CTRL_9V];
	wire req_12v = ctrl_reg[`ISTD_CTRL_12V];
	wire ext_clamp = ctrl_reg[`ISTD_CTRL_EXTCLAMP];
	wire detect_busy = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
	wire hv_allowed = hv_en && (req_9v || req_12v);
	wire wr_ctrl = bus_write && (bus_addr == `ISTD_ADDR_CTRL);
	wire wr_flags = bus_write && (bus_addr == `ISTD_ADDR_FLAGS);
	wire wr_mask = bus_write && (bus_addr == `ISTD_ADDR_MASK);
	wire wr_ilim = bus_write && (bus_addr == `ISTD_ADDR_ILIM);
	wire wr_drive = bus_write && (bus_addr == `ISTD_ADDR_DRIVE);
	reg port_done_evt;
	reg line_done_evt;
	// Status word: source code, port class done, line detect busy
	wire [31:0] status_word = {26'h000_0000, line_detect_status_reg, port_done_status_reg,
		src_code_reg};

	// Lower of register and pin clamp when the clamp bit is set, else the register; optimizer setting plays no part
	assign applied_current_limit = (ext_clamp && clamp_ma < ilim_reg) ? clamp_ma : ilim_reg; // R05

	// ==========================================
	// Input synchronisers (change counts when stages 2 and 3 agree)
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aux_sync <= 3'b000;
			aux_level <= 1'b0;
			qual_sync <= 3'b000;
			qual_level <= 1'b0;
		end else begin
			// Stage one may settle late; stages two and three vote
			aux_sync <= {aux_sync[1:0], first_aux_input};
			qual_sync <= {qual_sync[1:0], source_qualified};
			if (aux_sync[1] == aux_sync[2])
				aux_level <= aux_sync[2];
			if (qual_sync[1] == qual_sync[2])
				qual_level <= qual_sync[2];
		end
	end

	// ==========================================
	// Detection sequencer
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			stage_req <= REQ_NONE;
			hv_request_12v <= 1'b0;
			ilim_reg <= `ISTD_ILIM_RESET;
			src_code_reg <= `ISTD_SRC_NONE;
			port_done_status_reg <= 1'b0;
			line_detect_status_reg <= 1'b0;
			hv_twelve_tried_reg <= 1'b0;
			port_done_evt <= 1'b0;
			line_done_evt <= 1'b0;
		end else begin
			port_done_evt <= 1'b0;
			line_done_evt <= 1'b0;
			if (wr_ilim && !detect_busy)
				ilim_reg <= bus_wdata[11:0]; // R05 R15
			// Removal overrides a stage answer in the same cycle
			if (!aux_level && state_reg != ST_IDLE) begin
				state_reg <= ST_IDLE; // R23 R18
				stage_req <= REQ_NONE;
				line_detect_status_reg <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						// Start whenever the input is present, qualified and auto detection is on
						if (aux_level && qual_level && auto_en) begin // R01 R21 R06
							state_reg <= ST_CONTACT; // R07
							stage_req <= REQ_CONTACT;
							line_detect_status_reg <= 1'b1;
							port_done_status_reg <= 1'b0;
						end
					end
					ST_CONTACT: begin
						if (stage_done) begin
							state_reg <= ST_PRIMARY; // R07
							stage_req <= REQ_PRIMARY;
						end
					end
					ST_PRIMARY: begin
						if (stage_done) begin
							if (class_result == `ISTD_CLS_SDP) begin // R08 R10
								ilim_reg <= `ISTD_ILIM_SDP;
								src_code_reg <= `ISTD_SRC_SDP;
								port_done_status_reg <= 1'b1; // R02
								port_done_evt <= 1'b1;
								state_reg <= ST_DONE;
								stage_req <= REQ_NONE;
							end else if (class_result == `ISTD_CLS_OTHER) begin
								state_reg <= ST_DIVIDER; // R08
								stage_req <= REQ_DIVIDER;
							end else begin
								port_done_status_reg <= 1'b1; // R02
								port_done_evt <= 1'b1;
								state_reg <= ST_SECOND;
								stage_req <= REQ_SECOND;
							end
						end
					end
					ST_DIVIDER: begin
						if (stage_done) begin
							ilim_reg <= div_limit(divider_match); // R11 R24
							src_code_reg <= (divider_match >= 3'h1 && divider_match <= 3'h4) ?
								`ISTD_SRC_DIVIDER : `ISTD_SRC_UNKNOWN;
							state_reg <= ST_DONE;
							stage_req <= REQ_NONE;
						end
					end
					ST_SECOND: begin
						if (stage_done) begin
							if (class_result == `ISTD_CLS_CDP) begin // R09 R10
								ilim_reg <= `ISTD_ILIM_CDP;
								src_code_reg <= `ISTD_SRC_CDP;
								state_reg <= ST_DONE;
								stage_req <= REQ_NONE;
							end else begin
								ilim_reg <= `ISTD_ILIM_DCP; // R14 R10
								src_code_reg <= `ISTD_SRC_DCP;
								if (hv_allowed) begin // R03 R12
									state_reg <= ST_HV;
									stage_req <= REQ_HV;
									hv_request_12v <= req_12v;
									hv_twelve_tried_reg <= req_12v;
								end else begin
									state_reg <= ST_DONE;
									stage_req <= REQ_NONE;
								end
							end
						end
					end
					ST_HV: begin
						if (stage_done) begin
							if (hv_ack) begin
								ilim_reg <= `ISTD_ILIM_HIGH_VOLTAGE_DCP; // R14
								src_code_reg <= `ISTD_SRC_HIGH_VOLTAGE_DCP;
								state_reg <= ST_DONE;
								stage_req <= REQ_NONE;
							end else if (hv_twelve_tried_reg && req_9v) begin
								// Refused 12V falls back to 9V once, when asked
								hv_request_12v <= 1'b0; // R12
								hv_twelve_tried_reg <= 1'b0;
							end else begin
								state_reg <= ST_DONE;
								stage_req <= REQ_NONE;
							end
						end
					end
					ST_DONE: begin
						// Stay here until the source goes away
					end
					default: begin
						state_reg <= ST_IDLE;
						stage_req <= REQ_NONE;
					end
				endcase
				// Same cases that move to ST_DONE above; kept apart so the
				// done event stays a single cycle
				if (detect_busy && stage_done && state_reg != ST_CONTACT &&
					(state_reg != ST_PRIMARY || class_result == `ISTD_CLS_SDP) &&
					(state_reg != ST_SECOND || class_result == `ISTD_CLS_CDP || !hv_allowed) &&
					(state_reg != ST_HV || hv_ack || !(hv_twelve_tried_reg && req_9v))) begin
					line_detect_status_reg <= 1'b0; // R13 R04
					line_done_evt <= 1'b1;
				end
			end
		end
	end

	// ==========================================
	// Flags, masks, interrupt pulse; a set wins over a clear
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port_class_done_flag <= 1'b0;
			line_detect_done_flag <= 1'b0;
			port_class_done_mask <= 1'b0;
			line_detect_done_mask <= 1'b0;
			int_pulse <= 1'b0;
		end else begin
			if (wr_mask) begin
				port_class_done_mask <= bus_wdata[0];
				line_detect_done_mask <= bus_wdata[1];
			end
			// Masked events leave the flag alone and send no pulse
			if (port_done_evt && !port_class_done_mask)
				port_class_done_flag <= 1'b1; // R02
			else if (wr_flags && bus_wdata[0])
				port_class_done_flag <= 1'b0;
			if (line_done_evt && !line_detect_done_mask)
				line_detect_done_flag <= 1'b1; // R13
			else if (wr_flags && bus_wdata[1])
				line_detect_done_flag <= 1'b0;
			int_pulse <= (port_done_evt && !port_class_done_mask) ||
				(line_done_evt && !line_detect_done_mask); // R02 R13
		end
	end

	// ==========================================
	// Control, drive levels and converter start delay
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `ISTD_CTRL_RESET;
			plus_line_drive_level <= 4'h0;
			minus_line_drive_level <= 3'h0;
			delay_reg <= 32'h0000_0000;
			delay_run_reg <= 1'b0;
			converter_enable <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= bus_wdata[7:0];
			// Levels only reach the pins of the first input path
			if (wr_drive && !(aux_level && detect_busy)) begin // R16 R17 R18
				// Dropped writes are not replayed later
				plus_line_drive_level <= bus_wdata[3:0];
				minus_line_drive_level <= bus_wdata[6:4];
			end
			if (!aux_level) begin
				delay_run_reg <= 1'b0;
				converter_enable <= 1'b0;
			end else if (line_done_evt) begin
				delay_run_reg <= 1'b1; // R22
				delay_reg <= 32'h0000_0000;
			end else if (delay_run_reg) begin
				// Stops at its end value; converter stays on until removal
				if (delay_reg == DELAY_LAST) begin
					delay_run_reg <= 1'b0;
					converter_enable <= 1'b1; // R22
				end else begin
					delay_reg <= delay_reg + 32'h0000_0001;
				end
			end
		end
	end

	// ==========================================
	// Read port, data one cycle after the strobe
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_read) begin
			case (bus_addr)
				`ISTD_ADDR_CTRL: bus_rdata <= {24'h00_0000, ctrl_reg};
				`ISTD_ADDR_STATUS: bus_rdata <= status_word; // R04 R13
				`ISTD_ADDR_FLAGS: bus_rdata <= {30'h0000_0000, line_detect_done_flag,
					port_class_done_flag};
				`ISTD_ADDR_MASK: bus_rdata <= {30'h0000_0000, line_detect_done_mask,
					port_class_done_mask};
				`ISTD_ADDR_ILIM: bus_rdata <= {20'h0_0000, ilim_reg};
				`ISTD_ADDR_DRIVE: bus_rdata <= {25'h000_0000, minus_line_drive_level,
					plus_line_drive_level};
				`ISTD_ADDR_ADC: bus_rdata <= {6'h00, minus_line_adc, 6'h00, plus_line_adc}; // R20
				default: bus_rdata <= 32'h0000_0000;
			endcase
		end else begin
			// Zero outside the answer cycle keeps a shared read bus quiet
			bus_rdata <= 32'h0000_0000;
		end
	end
endmodule

// *** tb/istd_detector_asserts.sv ***
/*
 Port checker for the source type detector, bound to its top module.
 Assumes the front end holds each stage until stage_done is seen.
*/
`timescale 1ns/10ps
module istd_detector_asserts (
	input wire clk,
	input wire reset_n,
	input wire bus_read,
	input wire [31:0] bus_rdata,
	input wire stage_done,
	input wire hv_ack,
	input wire [2:0] stage_req,
	input wire hv_request_12v,
	input wire int_pulse
);
// ==========================================
// Port properties
default clocking cb @(posedge clk); endclocking
default disable iff (!reset_n);
rdata_idle_a: assert property (!$past(bus_read) |-> bus_rdata == 32'h0000_0000)
	else $error("read data not zero outside answer cycle");
pulse_one_a: assert property (int_pulse |=> !int_pulse)
	else $error("interrupt pulse longer than one cycle");
pulse_cause_a: assert property (int_pulse |-> $past(stage_done) || $past(stage_done, 2))
	else $error("interrupt pulse without a finished stage");
first_stage_a: assert property (stage_req == 3'h0 ##1 stage_req != 3'h0 |-> stage_req == 3'h1)
	else $error("detection did not start at contact detect");
contact_next_a: assert property (stage_req == 3'h1 ##1 stage_req != 3'h1 |->
	stage_req inside {3'h0, 3'h2})
	else $error("contact detect not followed by primary");
primary_next_a: assert property (stage_req == 3'h2 ##1 stage_req != 3'h2 |->
	stage_req inside {3'h0, 3'h3, 3'h4})
	else $error("primary not followed by divider or secondary");
second_next_a: assert property (stage_req == 3'h4 ##1 stage_req != 3'h4 |->
	stage_req inside {3'h0, 3'h5})
	else $error("secondary not followed by end or handshake");
last_stage_a: assert property ((stage_req == 3'h3 || stage_req == 3'h5) ##1
	stage_req != $past(stage_req) |-> stage_req == 3'h0)
	else $error("final stage not followed by idle");
advance_cause_a: assert property ($changed(stage_req) && stage_req != 3'h0 &&
	$past(stage_req) != 3'h0 |-> $past(stage_done))
	else $error("stage advanced without stage_done");
volt_order_a: assert property (stage_req == 3'h5 && $past(stage_req) == 3'h5 &&
	$changed(hv_request_12v) |-> !hv_request_12v && $past(stage_done) && !$past(hv_ack))
	else $error("handshake voltage order wrong");
cover property (stage_req == 3'h5);
cover property (stage_req == 3'h3);
cover property (int_pulse);
endmodule
bind istd_detector istd_detector_asserts u_chk (.clk(clk), .reset_n(reset_n),
	.bus_read(bus_read), .bus_rdata(bus_rdata), .stage_done(stage_done), .hv_ack(hv_ack),
	.stage_req(stage_req), .hv_request_12v(hv_request_12v), .int_pulse(int_pulse));

// *** tb/istd_front_model.sv ***
/*
 Analog front end and adapter model: answers each stage after lat cycles.
 Assumes stage_req and hv_request_12v are registered by the detector.
*/
`timescale 1ns/10ps
module istd_front_model (
	input wire clk,
	input wire [2:0] stage_req,
	input wire hv_request_12v,
	input wire [2:0] cls,
	input wire [2:0] div,
	input wire [1:0] ack,
	input wire [3:0] lat,
	output reg stage_done = 1'b0,
	output reg [2:0] class_result = 3'h0,
	output reg [2:0] divider_match = 3'h0,
	output reg hv_ack = 1'b0
);
// ==========================================
// Stage answers
reg [3:0] last = 4'h0;
reg [3:0] cnt = 4'h0;
always @(posedge clk) begin
	stage_done <= 1'b0;
	// Toggle outside pulses so stale results never pass
	class_result <= ~class_result;
	divider_match <= ~divider_match;
	hv_ack <= ~hv_ack;
	last <= {hv_request_12v, stage_req};
	if ({hv_request_12v, stage_req} != last) begin
		cnt <= lat;
	end else if (stage_req != 3'h0 && cnt != 4'h0) begin
		cnt <= cnt - 4'h1;
		if (cnt == 4'h1) begin
			stage_done <= 1'b1;
			// CDP answers are never revoked: the host enumerates in time
			class_result <= cls;
			divider_match <= div;
			hv_ack <= hv_request_12v ? ack[1] : ack[0];
		end
	end
end
endmodule

// *** tb/tb.sv ***
/*
 Self-checking bench for istd_detector with the front end model.
 Assumes istd_defines.vh is on the include path.
*/
`timescale 1ns/10ps
`include "istd_defines.vh"
module tb;
// ==========================================
// Wiring
localparam int DLY = 20;
reg clk = 1'b0;
reg reset_n = 1'b0;
reg [7:0] bus_addr = 8'h00;
reg [31:0] bus_wdata = 32'h0000_0000;
reg bus_write = 1'b0;
reg bus_read = 1'b0;
reg aux = 1'b0;
reg qual = 1'b0;
reg [11:0] clamp = 12'h000;
reg [9:0] adc_p = 10'h000;
reg [9:0] adc_m = 10'h000;
reg [2:0] m_cls = 3'h0;
reg [2:0] m_div = 3'h0;
reg [1:0] m_ack = 2'b00;
reg [3:0] m_lat = 4'h2;
reg [1:0] mk = 2'b00;
wire [31:0] bus_rdata;
wire stage_done, hv_ack, hv12, conv, int_pulse;
wire [2:0] cres, dmat, stage_req, mdrv;
wire [3:0] pdrv;
wire [11:0] ilim_out;
integer errors = 0;
integer compares = 0;
integer pulses = 0;
integer p0;
reg [31:0] exp_q[$];
reg [31:0] msk_q[$];
reg [31:0] m;
reg read_d = 1'b0;
reg in5 = 1'b0;
reg first12 = 1'b0;
reg [11:0] hvlim = 12'h000;
always #12.5 clk = ~clk;
istd_detector #(.START_DELAY_CYCLES(DLY)) dut (.clk(clk), .reset_n(reset_n),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
	.bus_rdata(bus_rdata), .first_aux_input(aux), .source_qualified(qual),
	.stage_done(stage_done), .class_result(cres), .divider_match(dmat), .hv_ack(hv_ack),
	.clamp_ma(clamp), .plus_line_adc(adc_p), .minus_line_adc(adc_m), .stage_req(stage_req),
	.hv_request_12v(hv12), .plus_line_drive_level(pdrv), .minus_line_drive_level(mdrv),
	.applied_current_limit(ilim_out), .converter_enable(conv), .int_pulse(int_pulse));
istd_front_model u_fe (.clk(clk), .stage_req(stage_req), .hv_request_12v(hv12),
	.cls(m_cls), .div(m_div), .ack(m_ack), .lat(m_lat), .stage_done(stage_done),
	.class_result(cres), .divider_match(dmat), .hv_ack(hv_ack));
// ==========================================
// Tasks and monitor
task automatic chk(input [31:0] got, input [31:0] e);
	compares = compares + 1;
	if (got !== e) begin
		errors = errors + 1;
		$display("[ERR] %0t got %h exp %h", $time, got, e);
	end
endtask
task automatic wr(input [7:0] a, input [31:0] d);
	@(posedge clk);
	bus_addr <= a;
	bus_wdata <= d;
	bus_write <= 1'b1;
	@(posedge clk);
	bus_write <= 1'b0;
endtask
task automatic rd(input [7:0] a, input [31:0] e, input [31:0] mm);
	@(posedge clk);
	bus_addr <= a;
	bus_read <= 1'b1;
	exp_q.push_back(e & mm);
	msk_q.push_back(mm);
	@(posedge clk);
	bus_read <= 1'b0;
endtask
task automatic wait_stage(input [2:0] s);
	integer n;
	n = 0;
	while (stage_req !== s && n < 300) begin
		@(posedge clk);
		n = n + 1;
	end
	chk({29'h0, stage_req}, {29'h0, s});
endtask
always @(posedge clk) begin
	read_d <= bus_read;
	if (int_pulse === 1'b1) pulses <= pulses + 1;
	in5 <= stage_req === 3'h5;
	if (stage_req === 3'h5 && !in5) begin
		first12 <= hv12;
		hvlim <= ilim_out;
	end
	if (read_d) begin
		m = msk_q.pop_front();
		chk(bus_rdata & m, exp_q.pop_front());
	end
end
task automatic detect(input [7:0] c, input [2:0] cl, input [2:0] dv, input [1:0] ak,
	input [3:0] code, input [11:0] lim);
	integer n;
	wr(`ISTD_ADDR_CTRL, {24'h0, c});
	m_cls <= cl;
	m_div <= dv;
	m_ack <= ak;
	m_lat <= 4'($urandom_range(6, 1));
	aux <= 1'b1;
	qual <= 1'b1;
	wait_stage(3'h1);
	rd(`ISTD_ADDR_STATUS, 32'h0000_0020, 32'h0000_0020);
	wait_stage(3'h0);
	if (conv !== 1'b1) begin
		n = 0;
		while (conv !== 1'b1 && n < 60) begin
			@(posedge clk);
			n = n + 1;
		end
		chk(n >= DLY - 2 && n <= DLY + 3, 32'h1);
	end
	rd(`ISTD_ADDR_STATUS, {28'h0, code}, 32'h0000_002F);
	rd(`ISTD_ADDR_ILIM, {20'h0, lim}, 32'h0000_0FFF);
	rd(`ISTD_ADDR_FLAGS, {30'h0, ~mk[1], 1'b0}, 32'h0000_0002);
	wr(`ISTD_ADDR_FLAGS, 32'h0000_0003);
	aux <= 1'b0;
	qual <= 1'b0;
	repeat (8) @(posedge clk);
endtask
task automatic stop_test;
	repeat (4) @(posedge clk);
	$display("errors=%0d compares=%0d", errors, compares);
	if (errors == 0 && compares > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
// ==========================================
// Sequence
initial begin
	#(25 * 40000);
	errors = errors + 1;
	stop_test;
end
initial begin
	void'($urandom(32'haedf47c1));
	repeat (6) @(posedge clk);
	reset_n <= 1'b1;
	rd(`ISTD_ADDR_CTRL, 32'h0000_0001, 32'h0000_003F);
	rd(`ISTD_ADDR_ILIM, 32'h0000_0BB8, 32'h0000_0FFF);
	rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
	p0 = pulses;
	detect(8'h01, 3'h0, 3'h0, 2'b00, `ISTD_SRC_SDP, `ISTD_ILIM_SDP);
	// SDP ends both events in one cycle, so they share one pulse
	chk(pulses - p0, 32'h1);
	mk = 2'b11;
	wr(`ISTD_ADDR_MASK, 32'h0000_0003);
	p0 = pulses;
	detect(8'h01, 3'h0, 3'h0, 2'b00, `ISTD_SRC_SDP, `ISTD_ILIM_SDP);
	chk(pulses - p0, 32'h0);
	mk = 2'b00;
	wr(`ISTD_ADDR_MASK, 32'h0000_0000);
	p0 = pulses;
	detect(8'h03, 3'h1, 3'h0, 2'b00, `ISTD_SRC_CDP, `ISTD_ILIM_CDP);
	chk(pulses - p0, 32'h2);
	detect(8'h05, 3'h2, 3'h0, 2'b11, `ISTD_SRC_DCP, `ISTD_ILIM_DCP);
	detect(8'h03, 3'h2, 3'h0, 2'b11, `ISTD_SRC_DCP, `ISTD_ILIM_DCP);
	detect(8'h01, 3'h3, 3'h1, 2'b00, `ISTD_SRC_DIVIDER, `ISTD_ILIM_DIV1);
	detect(8'h01, 3'h3, 3'h2, 2'b00, `ISTD_SRC_DIVIDER, `ISTD_ILIM_DIV2);
	detect(8'h01, 3'h3, 3'h3, 2'b00, `ISTD_SRC_DIVIDER, `ISTD_ILIM_DIV3);
	detect(8'h01, 3'h3, 3'h4, 2'b00, `ISTD_SRC_DIVIDER, `ISTD_ILIM_DIV4);
	detect(8'h01, 3'h3, 3'h7, 2'b00, `ISTD_SRC_UNKNOWN, `ISTD_ILIM_UNKNOWN);
	detect(8'h0F, 3'h2, 3'h0, 2'b01, `ISTD_SRC_HIGH_VOLTAGE_DCP, `ISTD_ILIM_HIGH_VOLTAGE_DCP);
	chk({31'h0, first12}, 32'h1);
	chk({20'h0, hvlim}, {20'h0, `ISTD_ILIM_DCP});
	detect(8'h0B, 3'h2, 3'h0, 2'b10, `ISTD_SRC_HIGH_VOLTAGE_DCP, `ISTD_ILIM_HIGH_VOLTAGE_DCP);
	wr(`ISTD_ADDR_ILIM, 32'h0000_05DC);
	rd(`ISTD_ADDR_ILIM, 32'h0000_05DC, 32'h0000_0FFF);
	wr(`ISTD_ADDR_CTRL, 32'h0000_0000);
	wr(`ISTD_ADDR_ILIM, 32'h0000_0123);
	aux <= 1'b1;
	qual <= 1'b1;
	repeat (30) @(posedge clk);
	chk({29'h0, stage_req}, 32'h0);
	rd(`ISTD_ADDR_ILIM, 32'h0000_0123, 32'h0000_0FFF);
	aux <= 1'b0;
	wr(`ISTD_ADDR_DRIVE, 32'h0000_0035);
	@(negedge clk);
	chk({28'h0, pdrv}, 32'h5);
	chk({29'h0, mdrv}, 32'h3);
	m_lat <= 4'hF;
	wr(`ISTD_ADDR_CTRL, 32'h0000_0001);
	aux <= 1'b1;
	wait_stage(3'h2);
	wr(`ISTD_ADDR_DRIVE, 32'h0000_004A);
	rd(`ISTD_ADDR_DRIVE, 32'h0000_0035, 32'h0000_007F);
	aux <= 1'b0;
	wait_stage(3'h0);
	rd(`ISTD_ADDR_STATUS, {28'h0, `ISTD_SRC_HIGH_VOLTAGE_DCP}, 32'h0000_002F);
	qual <= 1'b0;
	clamp <= 12'($urandom_range(3000, 100));
	adc_p <= 10'($urandom);
	adc_m <= 10'($urandom);
	wr(`ISTD_ADDR_CTRL, 32'h0000_0011);
	wr(`ISTD_ADDR_ILIM, 32'h0000_07D0);
	@(negedge clk);
	chk({20'h0, ilim_out}, {20'h0, clamp < 12'h7D0 ? clamp : 12'h7D0});
	wr(`ISTD_ADDR_CTRL, 32'h0000_0031);
	@(negedge clk);
	chk({20'h0, ilim_out}, {20'h0, clamp < 12'h7D0 ? clamp : 12'h7D0});
	wr(`ISTD_ADDR_CTRL, 32'h0000_0021);
	@(negedge clk);
	chk({20'h0, ilim_out}, 32'h0000_07D0);
	rd(`ISTD_ADDR_ADC, {6'h0, adc_m, 6'h0, adc_p}, 32'hFFFF_FFFF);
	stop_test;
end
endmodule
